// ---- verilog/pp_port.sv ----
// parallel master port: control register, ahb-lite slave and external bus cycle sequencer
// How it works
// [R1] enable bit clear: no external accesses
// [R2] bit 14 reads zero, ignores writes
// [R3] stop-in-idle set halts port during idle
// [R4] mux 10: 16 address bits on data
// [R5] mux 01: low byte on data, 10:8
// [R6] mux 00: address on its own pins
// [R7] bit 10 enables byte-enable pin drive
// [R8] bit 9 enables write strobe pin drive
// [R9] bit 8 enables read strobe pin drive
// [R10] chip-select function field gates chip select
// [R11] latch strobe polarity: 0 low, 1 high
// [R12] chip select polarity: 0 low, 1 high
// [R13] software avoids reserved mux and csf codes
module pp_port
    import pp_pkg::*;
#(
    parameter int STROBE_CYCLES = PP_STROBE_CYCLES
) (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        idle_mode_in,
    input  wire logic [7:0]  port_data_pins_in,
    output pp_pins_t         pins_out
);
    logic [15:0] control;
    logic [15:0] address;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic [7:0]  pins_meta;
    logic [7:0]  pins_sync;
    logic        dp_write;
    logic [3:0]  dp_ofs;
    logic        ap_valid;
    logic        cyc_write;
    logic        start_wr;
    logic        start_rd;
    logic        run;
    logic        busy;
    logic [1:0]  mux;
    logic [7:0]  strobe_cnt;
    pp_state_t   state;
    pp_pins_t    next_pins;
    logic [31:0] next_rdata;

    // zero wait states, so every transfer completes with OKAY in its first data-phase cycle
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign ap_valid      = hsel_in & hready_in & htrans_in[1];
    assign mux           = {control[PP_BIT_MUX_HI], control[PP_BIT_MUX_LO]};
    assign busy          = (state != PP_ST_IDLE);
    assign run           = control[PP_BIT_ENABLE] & ~(control[PP_BIT_STOP_IDLE] & idle_mode_in); // [R1] [R3]

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dp_write <= 1'b0;
            dp_ofs   <= 4'h0;
        end else begin
            dp_write <= ap_valid & hwrite_in;
            dp_ofs   <= haddr_in[3:0];
        end
    end

    // read data registered in the address phase so the data phase shows a flop
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr_in[3:0])
            PP_OFS_CONTROL: next_rdata[15:0] = control & PP_CONTROL_MASK; // [R2]
            PP_OFS_ADDRESS: next_rdata[15:0] = address;
            PP_OFS_WRDATA:  next_rdata[7:0]  = wr_data;
            PP_OFS_RDDATA:  next_rdata[8:0]  = {busy, rd_data};
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (ap_valid && !hwrite_in) begin
            hrdata_out <= next_rdata;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            control <= PP_CONTROL_RESET;
        end else if (dp_write && dp_ofs == PP_OFS_CONTROL) begin
            control <= hwdata_in[15:0] & PP_CONTROL_MASK; // [R2]
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            address <= PP_ADDRESS_RESET;
        end else if (dp_write && dp_ofs == PP_OFS_ADDRESS && !busy) begin
            address <= hwdata_in[15:0];
        end
    end

    // a write to the data register launches an external write; writes while busy are dropped
    assign start_wr = dp_write & (dp_ofs == PP_OFS_WRDATA) & ~busy & run; // [R1]
    assign start_rd = dp_write & (dp_ofs == PP_OFS_RDDATA) & ~busy & run; // [R1]

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_data <= PP_DATA_RESET;
        end else if (start_wr) begin
            wr_data <= hwdata_in[7:0];
        end
    end

    // pins come from outside the clock domain
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pins_meta <= 8'h00;
            pins_sync <= 8'h00;
        end else begin
            pins_meta <= port_data_pins_in;
            pins_sync <= pins_meta;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state      <= PP_ST_IDLE;
            strobe_cnt <= 8'h00;
            cyc_write  <= 1'b0;
            rd_data    <= PP_DATA_RESET;
        end else if (!control[PP_BIT_ENABLE]) begin
            state      <= PP_ST_IDLE; // [R1]
            strobe_cnt <= 8'h00;
        end else if (run) begin
            unique case (state)
                PP_ST_IDLE: begin
                    if (start_wr || start_rd) begin
                        cyc_write  <= start_wr;
                        strobe_cnt <= 8'h00;
                        state      <= (mux == PP_MUX_NONE) ? PP_ST_STROBE : PP_ST_LAT_LO; // [R6]
                    end
                end
                PP_ST_LAT_LO: begin
                    state <= (mux == PP_MUX_ALL16) ? PP_ST_LAT_HI : PP_ST_STROBE; // [R4] [R5]
                end
                PP_ST_LAT_HI: begin
                    state <= PP_ST_STROBE;
                end
                PP_ST_STROBE: begin
                    if (strobe_cnt == 8'(STROBE_CYCLES - 1)) begin
                        state <= PP_ST_IDLE;
                        if (!cyc_write) begin
                            rd_data <= pins_sync;
                        end
                    end else begin
                        strobe_cnt <= strobe_cnt + 8'h01;
                    end
                end
            endcase
        end
    end

    // pin values; stop-in-idle freezes the state, so the pins hold too
    always_comb begin
        next_pins         = '0;
        next_pins.al_lo   = ~control[PP_BIT_AL_POL]; // [R11]
        next_pins.al_hi   = ~control[PP_BIT_AL_POL]; // [R11]
        next_pins.rd      = ~control[PP_BIT_RD_POL];
        next_pins.wr      = ~control[PP_BIT_WR_POL];
        next_pins.be      = ~control[PP_BIT_BE_POL];
        next_pins.cs      = ~control[PP_BIT_CS_POL]; // [R12]
        next_pins.rd_oe   = control[PP_BIT_ENABLE] & control[PP_BIT_RD_EN]; // [R9]
        next_pins.wr_oe   = control[PP_BIT_ENABLE] & control[PP_BIT_WR_EN]; // [R8]
        next_pins.be_oe   = control[PP_BIT_ENABLE] & control[PP_BIT_BE_EN]; // [R7]
        next_pins.cs_oe   = control[PP_BIT_ENABLE] &
                            ({control[PP_BIT_CSF_HI], control[PP_BIT_CSF_LO]} == PP_CSF_CHIPSEL); // [R10]
        if (control[PP_BIT_ENABLE]) begin
            unique case (mux)
                PP_MUX_NONE: begin
                    next_pins.addr    = address; // [R6]
                    next_pins.addr_oe = 16'hffff;
                end
                PP_MUX_LOW8: begin
                    next_pins.addr[10:8]    = address[10:8]; // [R5]
                    next_pins.addr_oe[10:8] = 3'h7;
                end
                default: begin
                    next_pins.addr_oe = 16'h0000; // [R4]
                end
            endcase
        end
        if (busy) begin
            next_pins.cs = control[PP_BIT_CS_POL]; // [R12]
            next_pins.be = control[PP_BIT_BE_POL];
        end
        unique case (state)
            PP_ST_IDLE: begin
                next_pins.data_oe = 1'b0;
            end
            PP_ST_LAT_LO: begin
                next_pins.data    = address[7:0]; // [R4] [R5]
                next_pins.data_oe = 1'b1;
                next_pins.al_lo   = control[PP_BIT_AL_POL]; // [R11]
            end
            PP_ST_LAT_HI: begin
                next_pins.data    = address[15:8]; // [R4]
                next_pins.data_oe = 1'b1;
                next_pins.al_hi   = control[PP_BIT_AL_POL]; // [R11]
            end
            PP_ST_STROBE: begin
                next_pins.data    = cyc_write ? wr_data : 8'h00;
                next_pins.data_oe = cyc_write;
                if (cyc_write) begin
                    next_pins.wr = control[PP_BIT_WR_POL];
                end else begin
                    next_pins.rd = control[PP_BIT_RD_POL];
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pins_out <= '0;
        end else begin
            pins_out <= next_pins;
        end
    end
endmodule // pp_port

// ---- verilog/pp_pkg.sv ----
// package: register map, field layout, timing and carrier types of the parallel port
package pp_pkg;
    localparam logic [3:0]  PP_OFS_CONTROL   = 4'h0;
    localparam logic [3:0]  PP_OFS_ADDRESS   = 4'h4;
    localparam logic [3:0]  PP_OFS_WRDATA    = 4'h8;
    localparam logic [3:0]  PP_OFS_RDDATA    = 4'hc;
    localparam logic [15:0] PP_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] PP_CONTROL_MASK  = 16'hbfef;
    localparam logic [15:0] PP_ADDRESS_RESET = 16'h0000;
    localparam logic [7:0]  PP_DATA_RESET    = 8'h00;
    localparam int          PP_BIT_ENABLE    = 15;
    localparam int          PP_BIT_STOP_IDLE = 13;
    localparam int          PP_BIT_MUX_HI    = 12;
    localparam int          PP_BIT_MUX_LO    = 11;
    localparam int          PP_BIT_BE_EN     = 10;
    localparam int          PP_BIT_WR_EN     = 9;
    localparam int          PP_BIT_RD_EN     = 8;
    localparam int          PP_BIT_CSF_HI    = 7;
    localparam int          PP_BIT_CSF_LO    = 6;
    localparam int          PP_BIT_AL_POL    = 5;
    localparam int          PP_BIT_CS_POL    = 3;
    localparam int          PP_BIT_BE_POL    = 2;
    localparam int          PP_BIT_WR_POL    = 1;
    localparam int          PP_BIT_RD_POL    = 0;
    localparam int          PP_BIT_BUSY      = 8;
    localparam logic [1:0]  PP_MUX_NONE      = 2'h0;
    localparam logic [1:0]  PP_MUX_LOW8      = 2'h1;
    localparam logic [1:0]  PP_MUX_ALL16     = 2'h2;
    localparam logic [1:0]  PP_CSF_CHIPSEL   = 2'h2;
    localparam logic [1:0]  PP_HTRANS_NONSEQ = 2'h2;
    localparam int          PP_STROBE_NS     = 100;
    localparam int          PP_CLK_NS        = 25;
    localparam int          PP_STROBE_CYCLES = (PP_STROBE_NS + PP_CLK_NS - 1) / PP_CLK_NS;

    typedef enum logic [1:0] {
        PP_ST_IDLE,
        PP_ST_LAT_LO,
        PP_ST_LAT_HI,
        PP_ST_STROBE
    } pp_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] addr_oe;
        logic [7:0]  data;
        logic        data_oe;
        logic        rd;
        logic        rd_oe;
        logic        wr;
        logic        wr_oe;
        logic        be;
        logic        be_oe;
        logic        cs;
        logic        cs_oe;
        logic        al_lo;
        logic        al_hi;
    } pp_pins_t;
endpackage

// ---- sim/pp_chk.sv ----
// checker: pin-level assertions for the parallel port
module pp_chk
    import pp_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire pp_pins_t    pins_out
);
    logic [15:0] ctl, p1, p2;
    logic [3:0]  wa;
    logic [1:0]  lv;
    logic        wp;
    logic        ok;
    // shadow of the control word; pins lag it one edge, so only judge calm stretches
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {ctl, p1, p2, wa, lv, wp} <= '0;
        end else begin
            wp <= hsel_in && htrans_in[1] && hwrite_in;
            wa <= haddr_in[3:0];
            if (wp && wa == PP_OFS_CONTROL)
                ctl <= hwdata_in[15:0] & PP_CONTROL_MASK;
            {p2, p1} <= {p1, ctl};
            lv <= {lv[0], 1'b1};
        end
    end
    assign ok = lv[1] && ctl == p1 && p1 == p2;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_lat_lo;
        ok && ctl[12:11] == PP_MUX_ALL16 && pins_out.al_lo == ctl[5];
    endsequence
    sequence s_lat_hi;
        pins_out.al_hi == ctl[5] && pins_out.al_lo != ctl[5];
    endsequence
    a_off_quiet: assert property (ok && !ctl[15] |-> !pins_out.data_oe)
        else $error("data pins driven while disabled");
    a_mux_all: assert property (s_lat_lo |=> s_lat_hi)
        else $error("high latch did not follow low latch");
    a_mux_low: assert property (ok && ctl[12:11] == PP_MUX_LOW8 |-> pins_out.addr_oe[7:0] == 8'h00)
        else $error("low address pins driven in low-byte mode");
    a_mux_none: assert property (ok && ctl[12:11] == PP_MUX_NONE |-> pins_out.al_lo != ctl[5])
        else $error("latch strobe in separate mode");
    a_be_pin: assert property (ok && !ctl[10] |-> !pins_out.be_oe)
        else $error("byte enable driven");
    a_wr_pin: assert property (ok && !ctl[9] |-> !pins_out.wr_oe)
        else $error("write strobe driven");
    a_rd_pin: assert property (ok && !ctl[8] |-> !pins_out.rd_oe)
        else $error("read strobe driven");
    a_cs_func: assert property (ok && ctl[7:6] != PP_CSF_CHIPSEL |-> !pins_out.cs_oe)
        else $error("chip select driven");
    a_lat_idle: assert property (ok && !pins_out.data_oe
        |-> pins_out.al_lo != ctl[5] && pins_out.al_hi != ctl[5])
        else $error("latch strobe level wrong");
    a_cs_level: assert property (ok && ctl[15] && ctl[7:6] == PP_CSF_CHIPSEL && pins_out.al_lo == ctl[5]
        |-> pins_out.cs_oe && pins_out.cs == ctl[3])
        else $error("chip select level wrong");
endmodule // pp_chk

bind pp_port pp_chk u_chk (.*);

// ---- sim/pp_periph.sv ----
// partner: external peripheral answering read strobes on the data pins
module pp_periph
    import pp_pkg::*;
(
    input wire logic       clk_in,
    input wire pp_pins_t   pins_in,
    input wire logic       rd_pol_in,
    input wire logic [7:0] val_in,
    output logic     [7:0] data_out
);
    logic tg = 1'b0;
    always @(posedge clk_in) tg <= ~tg;
    // a released bus shows a moving pattern, never the last byte
    assign data_out = (pins_in.rd_oe && pins_in.rd === rd_pol_in) ? val_in : {8{tg}};
endmodule // pp_periph

// ---- sim/testbench.sv ----
// testbench: bus tasks, reference model and scenarios for the parallel port
module testbench
    import pp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SC = 4;
    logic        clk_in, rstn_in, hwr, idle, hro, hrs;
    logic [1:0]  htr;
    logic [31:0] had, hwd, hrd;
    logic [7:0]  pd, din, pval, seen, lo_seen, hi_seen;
    pp_pins_t    p;
    int          n_mismatch, n_compared, n_lo, n_hi, n_wr, n_rd, m_ctl;
    pp_port #(.STROBE_CYCLES(SC)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(1'b1), .haddr_in(had),
        .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(hro), .hrdata_out(hrd),
        .hreadyout_out(hro), .hresp_out(hrs), .idle_mode_in(idle), .port_data_pins_in(din), .pins_out(p));
    pp_periph u_per (.clk_in(clk_in), .pins_in(p), .rd_pol_in(m_ctl[0]), .val_in(pval), .data_out(pd));
    assign din = p.data_oe ? p.data : pd;
    always @(posedge clk_in) begin
        if (p.al_lo === m_ctl[5]) begin
            n_lo++;
            lo_seen = p.data;
        end
        if (p.al_hi === m_ctl[5]) begin
            n_hi++;
            hi_seen = p.data;
        end
        if (p.rd_oe && p.rd === m_ctl[0]) n_rd++;
        if (p.wr_oe && p.wr === m_ctl[1]) begin
            n_wr++;
            seen = p.data;
        end
    end
    task automatic test_done;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input int e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge clk_in);
        htr <= PP_HTRANS_NONSEQ;
        hwr <= w;
        had <= {28'h0, a};
        do @(posedge clk_in); while (hro !== 1'b1);
        htr <= 2'h0;
        hwd <= wd;
        do @(posedge clk_in); while (hro !== 1'b1);
        r = hrd;
        chk("hresp", 0, hrs);
    endtask
    task automatic poll(output logic [31:0] r);
        repeat (40) begin
            bus(0, PP_OFS_RDDATA, 0, r);
            if (r[PP_BIT_BUSY] === 1'b0) break;
        end
    endtask
    task automatic ext(input int m, input bit w);
        logic [31:0] r;
        int          c;
        int          v;
        int          a;
        c = 'h8380 | (m << 11) | ($urandom & 'h42f);
        v = $urandom & 'hff;
        a = $urandom;
        bus(1, PP_OFS_CONTROL, c, r);
        m_ctl = c;
        idle <= 1'($urandom);
        pval <= 8'(v);
        bus(1, PP_OFS_ADDRESS, a, r);
        {n_lo, n_hi, n_wr, n_rd} = '0;
        lo_seen = 'x;
        hi_seen = 'x;
        bus(1, w ? PP_OFS_WRDATA : PP_OFS_RDDATA, v, r);
        poll(r);
        chk("latch low", m != 0, n_lo);
        chk("latch high", m == 2, n_hi);
        chk("strobe", SC, w ? n_wr : n_rd);
        chk("data", v, w ? seen : r[7:0]);
        if (m != 0) chk("low address byte", a & 'hff, lo_seen);
        if (m == 2) chk("high address byte", (a >> 8) & 'hff, hi_seen);
        chk("address enables", m == 0 ? 'hffff : m == 1 ? 'h0700 : 0, p.addr_oe);
        chk("address pins", m == 0 ? a & 'hffff : m == 1 ? a & 'h0700 : 0, p.addr);
        bus(0, PP_OFS_ADDRESS, 0, r);
        chk("address readback", a & 'hffff, r);
        $display("test mux %0d dir %0d done", m, w);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // whole run is a few hundred cycles; the limit of twenty thousand cycles means a hang
    initial begin
        #500000;
        n_mismatch++;
        test_done;
    end
    initial begin
        logic [31:0] r;
        int          v;
        {rstn_in, hwr, idle, htr, had, hwd, pval, m_ctl} = '0;
        void'($urandom(32'he02ca9fd));
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        bus(0, PP_OFS_CONTROL, 0, r);
        chk("ctl reset", PP_CONTROL_RESET, r);
        repeat (6) begin
            v = ($urandom & 'haf3f) | 'h4080;
            bus(1, PP_OFS_CONTROL, v, r);
            bus(0, PP_OFS_CONTROL, 0, r);
            chk("ctl", v & 'hbfef, r);
        end
        $display("test control readback done");
        for (int m = 0; m < 3; m++) begin
            ext(m, 1);
            ext(m, 0);
        end
        bus(1, PP_OFS_CONTROL, 'h0380, r);
        m_ctl = 'h0380;
        idle <= 1'b0;
        n_wr = 0;
        bus(1, PP_OFS_WRDATA, 'h5a, r);
        bus(0, PP_OFS_RDDATA, 0, r);
        chk("disabled busy", 0, r[PP_BIT_BUSY]);
        repeat (12) @(posedge clk_in);
        chk("disabled", 0, n_wr);
        bus(1, PP_OFS_CONTROL, 'ha380, r);
        m_ctl = 'ha380;
        idle <= 1'b1;
        bus(1, PP_OFS_WRDATA, 'h5a, r);
        bus(0, PP_OFS_RDDATA, 0, r);
        chk("halted busy", 0, r[PP_BIT_BUSY]);
        repeat (12) @(posedge clk_in);
        chk("halted", 0, n_wr);
        idle <= 1'b0;
        bus(1, PP_OFS_WRDATA, 'h5a, r);
        poll(r);
        chk("resumed", SC, n_wr);
        $display("test enable and idle done");
        test_done;
    end
endmodule // testbench
